// File: design/i2c_slave_pkg.sv
// Package: register map, fields, reset values and timing for the two-wire slave
package i2c_slave_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_DATA    = 8'h00;
    localparam logic [7:0] ADDR_OWN     = 8'h04;
    localparam logic [7:0] ADDR_MODE    = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
    // Status register fields
    localparam int ST_DONE  = 7;
    localparam int ST_MATCH = 6;
    localparam int ST_BUSY  = 5;
    localparam int ST_TXSEL = 4;
    localparam int ST_ACKS  = 3;
    localparam int ST_DIR   = 2;
    localparam int ST_WAKE  = 1;
    localparam int ST_ACKR  = 0;
    localparam logic [7:0] STATUS_RST = 8'h81;
    // Time-out control fields
    localparam int TO_EN   = 7;
    localparam int TO_FLAG = 6;
    localparam logic [7:0] TIMEOUT_RST = 8'h00;
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [6:0] OWN_RST     = 7'h00;
    // Subsidiary clock ticks per time-out unit
    localparam int TO_TICK_DIV = 32;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_pair_t;
endpackage

// File: design/i2c_slave_with_timeout.sv
// Two-wire bus slave with SCL stretching, time-out and AXI4-Lite registers
`timescale 1ns/100ps
// Function
// - START sets bus busy flag
// - Receive 7 address bits, compare, interrupt
// - Eighth bit stored as direction flag
// - Acknowledge matching address at ninth clock
// - Address match sets matched status flag
// - Stretch SCL until software data access
// - Transmit select follows direction flag
// - Eight bit bytes, MSB first
// - Receiver drives ack control bit at ninth
// - Transmitter releases SDA on master nack
// - One data register for both directions
// - Time-out counts after match, cleared by fall
// - Time-out when period elapses without fall
// - STOP halts time-out counting
// - Overflow: stop, clear enable, set flag, interrupt
// - Time-out resets logic and status register
// - Period is (sel+1) times 32 sub clocks
// - Software clears time-out flag by writing
// - Enable bit7, flag bit6, select 5:0
// - STOP clears bus busy flag
// - Done flag cleared during byte, set after
module i2c_slave_with_timeout
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire i2c_slave_pkg::line_pair_t line_in,
    output logic                     scl_oe_n,
    output logic                     sda_oe_n,
    output logic                     scl_out,
    output logic                     sda_out,
    input  wire logic                subsidiary_clock,
    output logic                     irq
);
    import i2c_slave_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_RXACK, S_TX, S_TXACK}
        phase_t;

    ////////////////////////////////////////////////////////////////////////////
    // Line synchronisers
    logic [1:0] scl_sync_r, sda_sync_r, sub_sync_r;
    logic       scl_q_r, sda_q_r, sub_q_r;
    always_ff @(posedge aclk) begin
        scl_sync_r <= {scl_sync_r[0], line_in.scl};
        sda_sync_r <= {sda_sync_r[0], line_in.sda};
        sub_sync_r <= {sub_sync_r[0], subsidiary_clock};
        scl_q_r    <= scl_sync_r[1];
        sda_q_r    <= sda_sync_r[1];
        sub_q_r    <= sub_sync_r[1];
    end
    wire scl_s = scl_sync_r[1];
    wire sda_s = sda_sync_r[1];
    wire start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    wire stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;
    wire scl_rise  = scl_s & ~scl_q_r;
    wire scl_fall  = ~scl_s & scl_q_r;
    wire sub_rise  = sub_sync_r[1] & ~sub_q_r;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    phase_t     phase_r;
    logic [7:0] data_r, mode_r, status_r, tocr_r, shift_r;
    logic [6:0] own_r;
    logic [3:0] bit_cnt_r;
    logic       stretch_r, sda_low_r, irq_r, to_run_r;
    logic [4:0] tick_cnt_r;
    logic [5:0] unit_cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic       aw_hold_r, w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_now   = s_axi_awvalid & s_axi_awready;
    wire w_now    = s_axi_wvalid & s_axi_wready;
    wire aw_have  = aw_hold_r | aw_now;
    wire w_have   = w_hold_r | w_now;
    wire [7:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
    wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
    wire wr_go    = aw_have & w_have & ~s_axi_bvalid;
    wire wr_lane  = wr_go & ws[0];
    wire wr_data  = wr_lane & (wa == ADDR_DATA);
    wire wr_own   = wr_lane & (wa == ADDR_OWN);
    wire wr_mode  = wr_lane & (wa == ADDR_MODE);
    wire wr_stat  = wr_lane & (wa == ADDR_STATUS);
    wire wr_to    = wr_lane & (wa == ADDR_TIMEOUT);
    wire wr_map   = (wa == ADDR_DATA) | (wa == ADDR_OWN) | (wa == ADDR_MODE)
                  | (wa == ADDR_STATUS) | (wa == ADDR_TIMEOUT);
    wire ar_now   = s_axi_arvalid & s_axi_arready;
    wire rd_data  = ar_now & (s_axi_araddr == ADDR_DATA);
    logic [7:0] rd_val;
    logic       rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            ADDR_DATA:    rd_val = data_r;
            ADDR_OWN:     rd_val = {own_r, 1'b0};
            ADDR_MODE:    rd_val = mode_r;
            ADDR_STATUS:  rd_val = status_r;
            ADDR_TIMEOUT: rd_val = tocr_r;
            default: begin
                rd_val = 8'h00;
                rd_ok  = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else begin
            if (aw_now && !wr_go) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_now && !wr_go) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_now) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-out timer
    // Limit is (select + 1) units of 32 sub clocks; select in bits 5:0
    wire [5:0] to_sel    = tocr_r[5:0];
    wire       unit_tick = sub_rise & (tick_cnt_r == 5'(TO_TICK_DIV - 1));
    // Overflow when the last unit elapses without a fall
    wire       to_fire   = to_run_r & tocr_r[TO_EN] & unit_tick & (unit_cnt_r == to_sel)
                         & ~scl_fall;
    always_ff @(posedge aclk) begin
        // Held clear while disabled or stopped
        if (!aresetn || !tocr_r[TO_EN] || !to_run_r || scl_fall) begin
            tick_cnt_r <= 5'h00;
            unit_cnt_r <= 6'h00;
        end else if (sub_rise) begin
            tick_cnt_r <= tick_cnt_r + 5'h01;
            if (unit_tick) begin
                unit_cnt_r <= unit_cnt_r + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine
    wire addr_hit = (shift_r[7:1] == own_r);
    wire sw_release = wr_data | rd_data;
    always_ff @(posedge aclk) begin
        if (!aresetn || to_fire) begin
            // Time-out resets engine and status; data, own and mode kept
            phase_r   <= S_IDLE;
            status_r  <= STATUS_RST;
            shift_r   <= 8'h00;
            bit_cnt_r <= 4'h0;
            stretch_r <= 1'b0;
            sda_low_r <= 1'b0;
            to_run_r  <= 1'b0;
            irq_r     <= 1'b0;
            if (!aresetn) begin
                data_r <= 8'h00;
                own_r  <= OWN_RST;
                mode_r <= MODE_RST;
                tocr_r <= TIMEOUT_RST;
            end else begin
                // Stop, clear enable, set flag, interrupt
                tocr_r[TO_EN]   <= 1'b0;
                tocr_r[TO_FLAG] <= 1'b1;
                irq_r           <= 1'b1;
            end
        end else begin
            irq_r <= 1'b0;
            if (wr_own) own_r <= wd[7:1];
            if (wr_mode) mode_r <= wd[7:0];
            // Writes set enable and select; flag cleared by writing zero
            if (wr_to) tocr_r <= {wd[7], wd[6] & tocr_r[TO_FLAG], wd[5:0]};
            if (wr_stat) begin
                status_r[ST_TXSEL] <= wd[ST_TXSEL];
                status_r[ST_ACKS]  <= wd[ST_ACKS];
                status_r[ST_WAKE]  <= wd[ST_WAKE];
            end
            // Same register is loaded by software and by the bus
            if (wr_data) data_r <= wd[7:0];
            // Software access to the data register releases the stretched clock
            if (sw_release) stretch_r <= 1'b0;
            // Byte written during the stretch must go out first, not the stale one
            if (wr_data && stretch_r && phase_r == S_TX) begin
                shift_r   <= wd[7:0];
                sda_low_r <= ~wd[7];
            end
            if (start_det) begin
                status_r[ST_BUSY]  <= 1'b1;
                status_r[ST_MATCH] <= 1'b0;
                phase_r   <= S_ADDR;
                bit_cnt_r <= 4'h0;
                sda_low_r <= 1'b0;
            end else if (stop_det) begin
                status_r[ST_BUSY] <= 1'b0;
                phase_r   <= S_IDLE;
                sda_low_r <= 1'b0;
                to_run_r  <= 1'b0;
            end else if (scl_rise) begin
                case (phase_r)
                    S_ADDR, S_RX: begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    S_TXACK: begin
                        status_r[ST_ACKR] <= sda_s;
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (phase_r)
                    S_ADDR: begin
                        if (bit_cnt_r == 4'h8) begin
                            if (addr_hit) begin
                                phase_r   <= S_AACK;
                                sda_low_r <= 1'b1;
                                status_r[ST_DIR]   <= shift_r[0];
                                status_r[ST_TXSEL] <= shift_r[0];
                                status_r[ST_MATCH] <= 1'b1;
                                to_run_r <= 1'b1;
                            end else begin
                                phase_r <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        irq_r     <= 1'b1;
                        stretch_r <= 1'b1;
                        bit_cnt_r <= 4'h0;
                        phase_r   <= status_r[ST_TXSEL] ? S_TX : S_RX;
                        sda_low_r <= status_r[ST_TXSEL] & ~data_r[7];
                        shift_r   <= data_r;
                        status_r[ST_DONE] <= 1'b0;
                    end
                    S_RX: begin
                        status_r[ST_DONE] <= 1'b0;
                        if (bit_cnt_r == 4'h8) begin
                            data_r            <= shift_r;
                            status_r[ST_DONE] <= 1'b1;
                            irq_r             <= 1'b1;
                            phase_r           <= S_RXACK;
                            sda_low_r <= ~status_r[ST_ACKS];
                        end
                    end
                    S_RXACK: begin
                        sda_low_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        phase_r   <= S_RX;
                    end
                    S_TX: begin
                        status_r[ST_DONE] <= 1'b0;
                        if (bit_cnt_r == 4'h7) begin
                            sda_low_r <= 1'b0;
                            phase_r   <= S_TXACK;
                        end else begin
                            sda_low_r <= ~shift_r[6];
                            shift_r   <= {shift_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                    S_TXACK: begin
                        status_r[ST_DONE] <= 1'b1;
                        irq_r     <= 1'b1;
                        bit_cnt_r <= 4'h0;
                        if (status_r[ST_ACKR]) begin
                            phase_r   <= S_IDLE;
                            sda_low_r <= 1'b0;
                        end else begin
                            phase_r   <= S_TX;
                            sda_low_r <= ~data_r[7];
                            shift_r   <= data_r;
                        end
                    end
                    default: begin
                        phase_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Slave only pulls SDA low when SCL low or in ack, never a START
    assign sda_out  = 1'b0;
    assign scl_out  = 1'b0;
    assign sda_oe_n = ~sda_low_r;
    assign scl_oe_n = ~stretch_r;
    assign irq      = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        start_det && !to_fire |=> status_r[ST_BUSY])
        else $error("busy not set after start");
    chk_stop_free: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_det && !start_det |=> !status_r[ST_BUSY] && !to_run_r)
        else $error("busy or timer kept after stop");
    chk_match_ack: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_r == S_ADDR && scl_fall && bit_cnt_r == 4'h8 && shift_r[7:1] == own_r
        && !start_det && !stop_det && !to_fire
        |=> !sda_oe_n && status_r[ST_MATCH] && status_r[ST_DIR] == $past(shift_r[0]))
        else $error("address match not acknowledged");
    chk_stretch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        stretch_r && !sw_release && !to_fire |=> stretch_r)
        else $error("clock released without software access");
    chk_dir_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(status_r[ST_MATCH]) |-> status_r[ST_TXSEL] == status_r[ST_DIR])
        else $error("transmit select differs from direction");
    chk_to_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        to_fire |=> status_r == STATUS_RST && tocr_r[TO_FLAG] && !tocr_r[TO_EN]
        && phase_r == S_IDLE && irq)
        else $error("time-out did not reset interface");
    chk_to_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !tocr_r[TO_EN] |=> unit_cnt_r == 6'h00 && tick_cnt_r == 5'h00)
        else $error("counter moves while disabled");
    chk_fall_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        scl_fall |=> unit_cnt_r == 6'h00)
        else $error("counter not cleared by falling edge");
    chk_rx_done: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_r == S_RX && scl_fall && bit_cnt_r == 4'h8 && !start_det && !stop_det
        && !to_fire |=> status_r[ST_DONE] && irq && data_r == $past(shift_r))
        else $error("received byte not completed");
    cov_match: cover property (@(posedge aclk) $rose(status_r[ST_MATCH]));
    cov_rx: cover property (@(posedge aclk) phase_r == S_RXACK);
    cov_tx: cover property (@(posedge aclk) phase_r == S_TXACK);
    cov_to: cover property (@(posedge aclk) to_fire);
endmodule

// File: sim/i2c_master_model.sv
// Behavioural two-wire bus master on open-drain lines
`timescale 1ns/100ps
module i2c_master_model (
    input  wire logic aclk,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      scl_d,
    output logic      sda_d
);
    initial begin
        scl_d = 1'b1;
        sda_d = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Third of a bit, long next to the slave's sync delay
    task automatic half();
        repeat (8) @(posedge aclk);
    endtask
    // Slave may stretch, so wait for the wire itself
    task automatic rise();
        scl_d <= 1'b1;
        do @(posedge aclk); while (scl_w !== 1'b1);
        half();
    endtask
    task automatic start();
        sda_d <= 1'b1;
        half();
        rise();
        sda_d <= 1'b0;
        half();
        scl_d <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_d <= 1'b0;
        half();
        rise();
        sda_d <= 1'b1;
        half();
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_d <= b;
        half();
        rise();
        s = sda_w;
        scl_d <= 1'b0;
        half();
    endtask
    // eight bits MSB first, then ack bit
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask
endmodule

// File: sim/tb.sv
// Bench for the two-wire slave: registers, transfers and time-out
`timescale 1ns/100ps
module tb;
    import i2c_slave_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic        scl_oe_n, sda_oe_n, irq, scl_d, sda_d, ak;
    logic [2:0]  sub_cnt = 3'h0;
    logic [7:0]  rx;
    line_pair_t  line_in;
    int          err_total = 0;
    int          comparisons = 0;
    int          irq_cnt = 0;
    int          c;
    // Pull-ups: a line is low when any party pulls it
    assign line_in = '{scl: scl_d & scl_oe_n, sda: sda_d & sda_oe_n};
    always #10 aclk = ~aclk;
    // Fast subsidiary clock keeps time-out runs short
    always @(posedge aclk) sub_cnt <= sub_cnt + 3'h1;
    always @(posedge aclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    i2c_slave_with_timeout u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .scl_oe_n, .sda_oe_n,
        .scl_out(), .sda_out(), .subsidiary_clock(sub_cnt[2]), .irq);
    i2c_master_model u_master (.aclk, .scl_w(line_in.scl), .sda_w(line_in.sda), .scl_d, .sda_d);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input string w, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        check(w, {22'h0, r, d[7:0]}, {22'h0, RESP_OKAY, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk("status_rst", ADDR_STATUS, STATUS_RST); // reset value
        rchk("to_rst", ADDR_TIMEOUT, TIMEOUT_RST); // reset value
        wr(ADDR_TIMEOUT, 8'h3F);
        rchk("to_sel", ADDR_TIMEOUT, 8'h3F); // period field
        wr(ADDR_TIMEOUT, 8'h00);
        rd(8'h14);
        check("unmapped", 32'(r), 32'(RESP_SLVERR));
        wr(ADDR_OWN, 8'hA4);
        wr(ADDR_MODE, 8'h5A);
        u_master.start();
        u_master.xfer({7'h11, 1'b0}, 1'b1, rx, ak);
        check("nomatch_ack", 32'(ak), 32'h1); // no ack
        u_master.stop();
    endtask
    task automatic t_rx();
        c = irq_cnt;
        u_master.start();
        rd(ADDR_STATUS);
        check("busy_set", 32'(d[ST_BUSY]), 32'h1); // busy
        u_master.xfer({7'h52, 1'b0}, 1'b1, rx, ak);
        check("addr_ack", 32'(ak), 32'h0); // ack
        check("match_irq", 32'(irq_cnt - c), 32'h1); // interrupt
        rd(ADDR_STATUS);
        check("st_rx", 32'({d[ST_MATCH], d[ST_DIR], d[ST_TXSEL]}), 32'h4); // flags
        check("stretch", 32'(scl_oe_n), 32'h0); // held
        rd(ADDR_DATA);
        repeat (4) @(posedge aclk);
        check("unstretch", 32'(scl_oe_n), 32'h1); // freed
        u_master.xfer(8'hA5, 1'b1, rx, ak);
        check("data_ack", 32'(ak), 32'h0); // ack
        rchk("rx_byte", ADDR_DATA, 8'hA5); // byte
        rd(ADDR_STATUS);
        check("done", 32'(d[ST_DONE]), 32'h1); // done
        u_master.stop();
        rd(ADDR_STATUS);
        check("busy_clr", 32'(d[ST_BUSY]), 32'h0); // free
    endtask
    task automatic t_tx();
        u_master.start();
        u_master.xfer({7'h52, 1'b1}, 1'b1, rx, ak);
        rd(ADDR_STATUS);
        check("st_tx", 32'({d[ST_DIR], d[ST_TXSEL]}), 32'h3); // transmit
        wr(ADDR_DATA, 8'h3C);
        u_master.xfer(8'hFF, 1'b1, rx, ak);
        check("tx_byte", 32'(rx), 32'h3C); // byte
        repeat (4) @(posedge aclk);
        check("sda_free", 32'(sda_oe_n), 32'h1); // release
        u_master.stop();
    endtask
    task automatic t_timeout();
        wr(ADDR_TIMEOUT, 8'h80);
        c = irq_cnt;
        u_master.start();
        u_master.xfer({7'h52, 1'b0}, 1'b1, rx, ak);
        // Period 32 ticks of 8 cycles, plus sync slack
        repeat (200) @(posedge aclk);
        check("to_early", 32'(irq_cnt - c), 32'h1); // not yet
        repeat (120) @(posedge aclk);
        rchk("to_fired", ADDR_TIMEOUT, 8'h40); // flag
        check("to_irq", 32'(irq_cnt - c), 32'h2); // interrupt
        rchk("st_after", ADDR_STATUS, STATUS_RST); // status reset
        rchk("own_kept", ADDR_OWN, 8'hA4); // kept
        rchk("mode_kept", ADDR_MODE, 8'h5A); // kept
        rchk("data_kept", ADDR_DATA, 8'h3C); // kept
        check("to_unstretch", 32'(scl_oe_n), 32'h1); // logic reset
        wr(ADDR_TIMEOUT, 8'h00);
        rchk("to_clear", ADDR_TIMEOUT, 8'h00); // cleared
        u_master.stop();
    endtask
    task automatic conclude();
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge aclk);
        err_total++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_rx();
        t_tx();
        t_timeout();
        conclude();
    end
endmodule
